// file: hdl/pbs_pkg.sv
// Shared constants and types for the pipelined burst static RAM port.
`default_nettype none
package pbs_pkg;
	localparam logic [31:0] PBS_OFF_CTRL = 32'h0000_0000;
	localparam logic [31:0] PBS_OFF_STATUS = 32'h0000_0004;
	localparam logic [31:0] PBS_OFF_LOG = 32'h0000_0008;
	localparam logic [31:0] PBS_OFF_RDCNT = 32'h0000_000C;
	localparam logic [31:0] PBS_OFF_WRCNT = 32'h0000_0010;
	localparam int PBS_CTRL_LOG_EN = 0;
	localparam int PBS_ST_NONEMPTY = 0;
	localparam int PBS_ST_OVF = 1;
	localparam int PBS_ST_DESEL = 2;
	localparam int PBS_ST_HOLD = 3;
	localparam int PBS_ST_SLEEP = 4;
	localparam int PBS_LOG_VALID = 31;
	localparam int PBS_LOG_WRITE = 30;
	localparam int PBS_BURST_W = 2;
	localparam int PBS_LANE_BITS = 8;
	localparam int PBS_CNT_W = 16;
	localparam int PBS_LOG_DEPTH = 32;
	localparam logic PBS_CTRL_RST = 1'b1;
	localparam logic [1:0] PBS_BURST_ONE = 2'h1;
	localparam logic [1:0] PBS_HRESP_OKAY = 2'h0;

	typedef enum logic [1:0] {PBS_OP_DESEL, PBS_OP_READ, PBS_OP_WRITE} pbs_op_t;

	// Control pins; cs holds the first select (low), second (high), third (low).
	typedef struct packed {
		logic step;
		logic we_n;
		logic [2:0] cs;
		logic hold;
		logic sleep;
		logic oe_n;
		logic order;
	} pbs_ctl_t;

	function automatic logic [1:0] pbs_burst_low(logic [1:0] base, logic [1:0] cnt,
		logic interleave);
		pbs_burst_low = interleave ? (base ^ cnt) : 2'(base + cnt);
	endfunction

	function automatic logic pbs_selected(logic [2:0] cs);
		pbs_selected = !cs[2] && cs[1] && !cs[0];
	endfunction
endpackage
`default_nettype wire

// file: hdl/pbs_sram_port.sv
// Pipelined no-wait burst static RAM port with an access log read over AHB-Lite.
`default_nettype none

module pbs_fifo #(
	parameter int W = 19,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] count;
	} st_t;
	st_t s, n;

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("pbs_fifo depth must be a power of two");
	end

	assign in_ready = s.count != (AW + 1)'(DEPTH);
	assign out_valid = s.count != '0;
	assign out_data = s.mem[s.rp];

	always_comb begin
		logic push;
		logic pop;
		push = 1'b0;
		pop = 1'b0;
		n = s;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		if (push) begin
			n.mem[s.wp] = in_data;
			n.wp = AW'(s.wp + 1'b1);
		end
		if (pop) begin
			n.rp = AW'(s.rp + 1'b1);
		end
		n.count = (AW + 1)'(s.count + push - pop);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end
endmodule

module pbs_sram_port
	import pbs_pkg::*;
#(
	parameter int ADDR_W = 18,
	parameter int LANES = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [1:0] hresp,
	output logic [31:0] hrdata,
	input wire pbs_ctl_t ctl_pins,
	input wire logic [ADDR_W-3:0] addr_hi,
	input wire logic [PBS_BURST_W-1:0] burst_low_addr_bits,
	input wire logic [LANES-1:0] byte_lane_write_n,
	input wire logic [LANES*PBS_LANE_BITS-1:0] data_io_lanes_i,
	output logic [LANES*PBS_LANE_BITS-1:0] data_io_lanes_o,
	output logic data_io_lanes_oe,
	input wire logic [LANES-1:0] parity_io_lanes_i,
	output logic [LANES-1:0] parity_io_lanes_o,
	output logic parity_io_lanes_oe
);
	localparam int DW = LANES * PBS_LANE_BITS;
	localparam int WORD_W = DW + LANES;
	localparam int LOG_W = ADDR_W + 1;

	if ((LANES != 4 && LANES != 8) || ADDR_W < 3 || ADDR_W > 30) begin : g_chk
		$error("pbs_sram_port supports 4 or 8 lanes and 3 to 30 address bits");
	end

	typedef struct packed {
		pbs_ctl_t ctl;
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0] bw_n;
		logic [WORD_W-1:0] din;
	} in_t;

	typedef struct packed {
		in_t s1;
		in_t s2;
		pbs_op_t op;
		logic [ADDR_W-1:0] base;
		logic [PBS_BURST_W-1:0] cnt;
		logic [LANES-1:0] bw_n;
		logic desel_seen;
		logic drive;
		logic oe;
		logic [WORD_W-1:0] dq;
		logic ap_valid;
		logic ap_write;
		logic [31:0] ap_addr;
		logic [31:0] hrdata;
		logic hready;
		logic log_en;
		logic ovf;
		logic [PBS_CNT_W-1:0] rd_cnt;
		logic [PBS_CNT_W-1:0] wr_cnt;
	} st_t;

	st_t s, n;
	in_t pins;
	logic [WORD_W-1:0] mem_q [2**ADDR_W];
	logic [ADDR_W-1:0] cur_addr;
	logic wr_en;
	logic push;
	logic pop;
	logic log_ready;
	logic log_valid;
	logic [LOG_W-1:0] log_data;

	assign pins = '{ctl: ctl_pins, addr: {addr_hi, burst_low_addr_bits},
		bw_n: byte_lane_write_n, din: {parity_io_lanes_i, data_io_lanes_i}};

	// burst address in the pinned order
	assign cur_addr = {s.base[ADDR_W-1:PBS_BURST_W],
		pbs_burst_low(s.base[PBS_BURST_W-1:0], s.cnt, s.s2.ctl.order)};
	// self-timed array write in the data slot
	assign wr_en = !s.s2.ctl.hold && s.op == PBS_OP_WRITE;
	assign push = !s.s2.ctl.hold && s.log_en && s.op != PBS_OP_DESEL;

	// The log fills only while log_en is set; a full log drops entries and flags it.
	pbs_fifo #(.W(LOG_W), .DEPTH(PBS_LOG_DEPTH)) u_log (
		.clk(hclk),
		.rst_n(hresetn),
		.in_valid(push),
		.in_ready(log_ready),
		.in_data({s.op == PBS_OP_WRITE, cur_addr}),
		.out_valid(log_valid),
		.out_ready(pop),
		.out_data(log_data)
	);

	always_comb begin
		logic acc;
		acc = 1'b0;
		n = s;
		pop = 1'b0;
		n.s1 = pins;
		n.s2 = s.s1;
		n.hready = 1'b1;
		if (!s.s2.ctl.hold) begin
			// read word lands one clock after its address edge
			n.drive = s.op == PBS_OP_READ;
			if (s.op == PBS_OP_READ) begin
				n.dq = mem_q[cur_addr];
				n.rd_cnt = PBS_CNT_W'(s.rd_cnt + 1'b1);
			end
			if (wr_en && !(&s.bw_n)) begin
				n.wr_cnt = PBS_CNT_W'(s.wr_cnt + 1'b1);
			end
			n.bw_n = s.s2.bw_n;
			// only a low burst-step starts a new cycle
			if (!s.s2.ctl.step) begin
				n.base = s.s2.addr;
				n.cnt = '0;
				if (!pbs_selected(s.s2.ctl.cs)) begin
					n.op = PBS_OP_DESEL;
					n.desel_seen = 1'b1;
				end else begin
					// read or write on any edge, no idle needed
					n.op = s.s2.ctl.we_n ? PBS_OP_READ : PBS_OP_WRITE;
					n.desel_seen = 1'b0;
				end
			end else begin
				// advance the count; a deselect stays deselected
				n.cnt = PBS_BURST_W'(s.cnt + PBS_BURST_ONE);
			end
		end
		// lanes driven only in a read slot, never under sleep or high oe_n
		n.oe = n.drive && !s.s2.ctl.oe_n && !s.s2.ctl.sleep;

		if (s.ap_valid && s.ap_write) begin
			if (s.ap_addr == PBS_OFF_CTRL) begin
				n.log_en = hwdata[PBS_CTRL_LOG_EN];
			end
			if (s.ap_addr == PBS_OFF_STATUS && hwdata[PBS_ST_OVF]) begin
				n.ovf = 1'b0;
			end
		end
		// A drop in the same cycle as the clear keeps the flag set.
		if (push && !log_ready) begin
			n.ovf = 1'b1;
		end
		acc = hsel && htrans[1] && hready;
		n.ap_valid = acc;
		n.ap_write = hwrite;
		n.ap_addr = haddr;
		if (acc && !hwrite) begin
			unique case (haddr)
				PBS_OFF_CTRL: n.hrdata = 32'(s.log_en);
				PBS_OFF_STATUS: n.hrdata = 32'({s.s2.ctl.sleep, s.s2.ctl.hold,
					s.desel_seen, s.ovf, log_valid});
				PBS_OFF_LOG: begin
					n.hrdata = '0;
					n.hrdata[LOG_W-1:0] = log_data;
					n.hrdata[PBS_LOG_WRITE] = log_data[LOG_W-1];
					n.hrdata[ADDR_W] = 1'b0;
					n.hrdata[PBS_LOG_VALID] = log_valid;
					pop = log_valid;
				end
				PBS_OFF_RDCNT: n.hrdata = 32'(s.rd_cnt);
				PBS_OFF_WRCNT: n.hrdata = 32'(s.wr_cnt);
				default: n.hrdata = '0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.hready <= 1'b1;
			s.log_en <= PBS_CTRL_RST;
		end else begin
			s <= n;
		end
	end

	// masked lane write with data from the following edge
	always_ff @(posedge hclk) begin
		if (wr_en) begin
			for (int i = 0; i < LANES; i++) begin
				if (!s.bw_n[i]) begin
					mem_q[cur_addr][i*PBS_LANE_BITS +: PBS_LANE_BITS] <=
						s.s2.din[i*PBS_LANE_BITS +: PBS_LANE_BITS];
					mem_q[cur_addr][DW+i] <= s.s2.din[DW+i];
				end
			end
		end
	end

	assign hreadyout = s.hready;
	assign hresp = PBS_HRESP_OKAY;
	assign hrdata = s.hrdata;
	assign data_io_lanes_o = s.dq[DW-1:0];
	assign parity_io_lanes_o = s.dq[WORD_W-1:DW];
	assign data_io_lanes_oe = s.oe;
	assign parity_io_lanes_oe = s.oe;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_live;
		!s.s2.ctl.hold;
	endsequence
	sequence s_addr_edge;
		s_live and !s.s2.ctl.step;
	endsequence
	sequence s_step_edge;
		s_live and s.s2.ctl.step;
	endsequence
	sequence s_read_start;
		s_addr_edge and pbs_selected(s.s2.ctl.cs) && s.s2.ctl.we_n;
	endsequence
	sequence s_write_start;
		s_addr_edge and pbs_selected(s.s2.ctl.cs) && !s.s2.ctl.we_n;
	endsequence

	a_hold_freeze: assert property (s.s2.ctl.hold |=>
		$stable(s.op) && $stable(s.base) && $stable(s.cnt) && $stable(s.dq))
		else $error("state moved during clock hold");
	a_addr_load: assert property (s_addr_edge |=>
		s.base == $past(s.s2.addr) && s.cnt == '0)
		else $error("address not loaded on low burst step");
	a_burst_adv: assert property (s_step_edge |=>
		s.cnt == PBS_BURST_W'($past(s.cnt) + PBS_BURST_ONE) && $stable(s.op))
		else $error("burst count did not advance");
	a_read_slot: assert property (s_read_start ##1 s_live |=>
		s.drive && s.rd_cnt == PBS_CNT_W'($past(s.rd_cnt) + 1'b1))
		else $error("read data slot missing after read address");
	a_write_quiet: assert property (s.op == PBS_OP_WRITE && !s.s2.ctl.hold |=>
		!s.oe)
		else $error("lanes driven during a write slot");
	a_sleep_float: assert property (s.s2.ctl.sleep |=> !s.oe)
		else $error("lanes driven while asleep");
	a_desel_cont: assert property (s.op == PBS_OP_DESEL ##0 s_step_edge |=>
		s.op == PBS_OP_DESEL)
		else $error("continue deselect left the deselected state");
	a_lin_order: assert property (!s.s2.ctl.order && s.cnt == 2'h3 |->
		cur_addr[1:0] == 2'(s.base[1:0] + 2'h3))
		else $error("linear burst order wrong");
	a_log_drop: assert property (push && !log_ready |=> s.ovf)
		else $error("dropped log entry not flagged");
	a_write_slot: assert property (s_write_start |=>
		s.op == PBS_OP_WRITE && s.cnt == '0)
		else $error("write slot not opened on write select");
	a_hold_ignore: assert property (s.s2.ctl.hold |=>
		$stable(s.bw_n) && $stable(s.drive) && $stable(s.rd_cnt) && $stable(s.wr_cnt))
		else $error("held edge took an input");
	a_inter_order: assert property (s.s2.ctl.order && s.cnt == 2'h3 |->
		cur_addr[1:0] == (s.base[1:0] ^ 2'h3))
		else $error("interleaved burst order wrong");
endmodule
`default_nettype wire

// file: verification/pbs_ctl_model.sv
// Memory controller model that drives the static RAM pins of the port.
`default_nettype none
module pbs_ctl_model
	import pbs_pkg::*;
(
	input wire logic hclk,
	output pbs_ctl_t ctl,
	output logic [5:0] adr,
	output logic [7:0] bw_n,
	output logic [71:0] drv,
	input wire logic [71:0] seen,
	input wire logic oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [71:0] pend = '0;
	logic pend_v = 1'b0;
	logic ord = 1'b0;
	logic slp = 1'b0;
	logic oen = 1'b0;
	int n_rd = 0;
	int n_wr = 0;
	logic [71:0] rq[$];
	initial begin
		ctl = '{1'b0, 1'b1, 3'b111, 1'b0, 1'b0, 1'b0, 1'b0};
		adr = '0;
		bw_n = 8'hFF;
		drv = '0;
	end
	// step low starts a cycle at the full address.
	task automatic op(input logic st, we, hd, sel, input logic [5:0] a,
		input logic [7:0] bw, input logic [71:0] wd);
		@(posedge hclk);
		ctl <= '{st, we, sel ? 3'b010 : 3'b111, hd, slp, oen, ord};
		adr <= a;
		bw_n <= bw;
		// Write data trails its address; idle lanes show the inverse.
		drv <= pend_v ? pend : ~drv;
		pend <= wd;
		pend_v <= !hd && sel && !we;
		if (!hd && sel) begin
			if (we) n_rd++;
			else n_wr++;
		end
	endtask
	// Repeated words are folded so that a stalled output counts once.
	always @(negedge hclk) begin
		if (oe === 1'b1 && (rq.size() == 0 || rq[$] !== seen)) rq.push_back(seen);
	end
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the burst static RAM port and its access log.
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_top
	import pbs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic hrdy;
	logic [1:0] hresp;
	logic [31:0] hrdata;
	pbs_ctl_t ctl;
	logic [5:0] adr;
	logic [7:0] bw_n;
	logic [71:0] drv;
	logic [63:0] dq_o;
	logic [7:0] dqp_o;
	logic dq_oe;
	logic dqp_oe;
	logic [71:0] seen;
	logic [71:0] em [0:63];
	logic [31:0] r;
	int bad_count = 0;
	int n_compared = 0;
	always #10 hclk = ~hclk;
	assign seen = {dqp_oe ? dqp_o : drv[71:64], dq_oe ? dq_o : drv[63:0]};
	pbs_sram_port #(.ADDR_W(6), .LANES(8)) u_pbs_sram_port (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp),
		.hrdata(hrdata), .ctl_pins(ctl), .addr_hi(adr[5:2]), .burst_low_addr_bits(adr[1:0]),
		.byte_lane_write_n(bw_n), .data_io_lanes_i(seen[63:0]), .data_io_lanes_o(dq_o),
		.data_io_lanes_oe(dq_oe), .parity_io_lanes_i(seen[71:64]),
		.parity_io_lanes_o(dqp_o), .parity_io_lanes_oe(dqp_oe));
	pbs_ctl_model u_ctl (.hclk(hclk), .ctl(ctl), .adr(adr), .bw_n(bw_n), .drv(drv),
		.seen(seen), .oe(dq_oe));
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wait_rdy;
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hrdy !== 1'b1 && i < 50);
		if (hrdy !== 1'b1) begin
			bad_count++;
			report_and_stop;
		end
	endtask
	task automatic ahb(input logic wr, input logic [31:0] a, d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		r = hrdata;
	endtask
	function automatic logic [71:0] pat(input int k);
		pat = {8'(k * 37), 64'h0123_4567_89AB_CDEF ^ {8{8'(k * 29)}}};
	endfunction
	task automatic idle(input int n);
		repeat (n) u_ctl.op(1'b0, 1'b1, 1'b0, 1'b0, 6'h00, 8'hFF, '0);
	endtask
	task automatic chk_q(input logic [71:0] e[$]);
		`CHK("read count", e.size(), u_ctl.rq.size())
		for (int i = 0; i < e.size() && i < u_ctl.rq.size(); i++)
			`CHK("read word", e[i], u_ctl.rq[i])
	endtask
	// Burst words walk the two-bit counter in the chosen order.
	task automatic burst(input logic wr, input logic [5:0] a, input int k);
		logic [5:0] w;
		logic [71:0] e[$];
		u_ctl.rq.delete();
		for (int i = 0; i < 4; i++) begin
			w = {a[5:2], u_ctl.ord ? a[1:0] ^ 2'(i) : 2'(a[1:0] + 2'(i))};
			u_ctl.op(i != 0, !wr, 1'b0, 1'b1, a, 8'h00, pat(k + i));
			if (wr) em[w] = pat(k + i);
			else e.push_back(em[w]);
		end
		idle(6);
		if (!wr) chk_q(e);
	endtask
	// Back-to-back single reads, one new address on every edge.
	task automatic singles(input logic [5:0] a0);
		logic [71:0] e[$];
		u_ctl.rq.delete();
		for (int i = 0; i < 4; i++) begin
			u_ctl.op(1'b0, 1'b1, 1'b0, 1'b1, a0 + 6'(i), 8'h00, '0);
			e.push_back(em[a0 + 6'(i)]);
		end
		idle(6);
		chk_q(e);
	endtask
	// A held edge ignores a write start and the burst resumes in place.
	task automatic hold_case;
		u_ctl.rq.delete();
		u_ctl.op(1'b0, 1'b1, 1'b0, 1'b1, 6'h04, 8'h00, '0);
		u_ctl.op(1'b1, 1'b1, 1'b0, 1'b1, 6'h04, 8'h00, '0);
		u_ctl.op(1'b0, 1'b0, 1'b1, 1'b1, 6'h3C, 8'h00, pat(99));
		u_ctl.op(1'b1, 1'b1, 1'b0, 1'b1, 6'h04, 8'h00, '0);
		idle(6);
		chk_q('{em[6'h04], em[6'h05], em[6'h06]});
	endtask
	// Only low-enabled lanes take the byte and its parity bit.
	task automatic lanes_case;
		logic [71:0] m;
		m = {8'h0F, 64'h0000_0000_FFFF_FFFF};
		em[6'h05] = (em[6'h05] & ~m) | (pat(50) & m);
		u_ctl.op(1'b0, 1'b0, 1'b0, 1'b1, 6'h05, 8'hF0, pat(50));
		singles(6'h04);
	endtask
	// Deselect, then continues: no slot and no data.
	task automatic desel_case;
		u_ctl.rq.delete();
		u_ctl.op(1'b0, 1'b1, 1'b0, 1'b0, 6'h04, 8'h00, '0);
		repeat (2) u_ctl.op(1'b1, 1'b1, 1'b0, 1'b0, 6'h04, 8'h00, '0);
		idle(4);
		ahb(1'b0, PBS_OFF_STATUS, '0);
		`CHK("deselect flag", 1'b1, r[PBS_ST_DESEL])
		`CHK("deselect words", 0, u_ctl.rq.size())
	endtask
	// A high output-enable-n or sleep keeps the lanes released.
	task automatic quiet_case;
		u_ctl.rq.delete();
		u_ctl.oen = 1'b1;
		u_ctl.op(1'b0, 1'b1, 1'b0, 1'b1, 6'h04, 8'h00, '0);
		idle(4);
		u_ctl.oen = 1'b0;
		u_ctl.slp = 1'b1;
		u_ctl.op(1'b0, 1'b1, 1'b0, 1'b1, 6'h05, 8'h00, '0);
		idle(4);
		ahb(1'b0, PBS_OFF_STATUS, '0);
		`CHK("sleep flag", 1'b1, r[PBS_ST_SLEEP])
		u_ctl.slp = 1'b0;
		idle(4);
		`CHK("released words", 0, u_ctl.rq.size())
	endtask
	// The log must overflow, clear on a written one and drain empty.
	task automatic log_case;
		int n;
		singles(6'h08);
		singles(6'h04);
		ahb(1'b0, PBS_OFF_STATUS, '0);
		`CHK("overflow", 1'b1, r[PBS_ST_OVF])
		`CHK("log nonempty", 1'b1, r[PBS_ST_NONEMPTY])
		ahb(1'b1, PBS_OFF_STATUS, 32'h0000_0002);
		ahb(1'b0, PBS_OFF_STATUS, '0);
		`CHK("overflow cleared", 1'b0, r[PBS_ST_OVF])
		n = 0;
		do begin
			ahb(1'b0, PBS_OFF_LOG, '0);
			// The oldest kept entry is the first word of the opening write burst.
			if (n == 0) `CHK("first log entry", 32'hC000_0006, r)
			if (r[PBS_LOG_VALID] === 1'b1) n++;
		end while (r[PBS_LOG_VALID] === 1'b1 && n < 40);
		`CHK("log entries", PBS_LOG_DEPTH, n)
		ahb(1'b0, PBS_OFF_RDCNT, '0);
		`CHK("read slots", u_ctl.n_rd[15:0], r[15:0])
		ahb(1'b0, PBS_OFF_WRCNT, '0);
		`CHK("write slots", u_ctl.n_wr[15:0], r[15:0])
		ahb(1'b1, PBS_OFF_CTRL, '0);
		ahb(1'b0, PBS_OFF_CTRL, '0);
		`CHK("log enable written", 1'b0, r[PBS_CTRL_LOG_EN])
	endtask
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		idle(3);
		ahb(1'b0, PBS_OFF_CTRL, '0);
		`CHK("ctrl reset", PBS_CTRL_RST, r[PBS_CTRL_LOG_EN])
		ahb(1'b0, 32'h0000_0040, '0);
		`CHK("unmapped", 32'h0000_0000, r)
		`CHK("response", PBS_HRESP_OKAY, hresp)
		burst(1'b1, 6'h06, 0);
		singles(6'h04);
		u_ctl.ord = 1'b1;
		idle(4);
		burst(1'b1, 6'h09, 4);
		singles(6'h08);
		burst(1'b0, 6'h0A, 0);
		hold_case;
		lanes_case;
		desel_case;
		quiet_case;
		log_case;
		report_and_stop;
	end
endmodule
`default_nettype wire
